// ### include/clg_consts.svh
`ifndef CLG_CONSTS_SVH
`define CLG_CONSTS_SVH

// Register byte offsets
`define CLG_OFF_CTRL 8'h00
`define CLG_OFF_INV 8'h04
`define CLG_OFF_CONN 8'h08
`define CLG_OFF_TIME 8'h0c
`define CLG_OFF_LIMIT 8'h10
`define CLG_OFF_STATUS 8'h14
`define CLG_OFF_COUNT 8'h18
`define CLG_OFF_HOURS 8'h1c

// Control bit positions
`define CLG_CTRL_RETAIN 0
`define CLG_CTRL_PROG 1
`define CLG_CTRL_PROT 2

// Special function input positions in sf_in; INV and CONN hold them four bits higher
`define CLG_SF_SET 0
`define CLG_SF_RST 1
`define CLG_SF_TRG 2
`define CLG_SF_DIR 3
`define CLG_SF_EN 4
`define CLG_SF_INV 5
`define CLG_SF_RAL 6

// Reset values
`define CLG_RST_CTRL 3'h0
`define CLG_RST_INV 11'h000
`define CLG_RST_CONN 11'h7ff
`define CLG_RST_TIME 18'h00000
`define CLG_RST_LIMIT 16'h000a

// Timing: clock period, hundredth tick, program cycle (ns)
`define CLG_CLK_NS 5
`define CLG_HUND_NS 10000000
`define CLG_PCYCLE_NS 100000
`define CLG_HUND_CYCLES (`CLG_HUND_NS / `CLG_CLK_NS)
`define CLG_PCYCLE_CYCLES (`CLG_PCYCLE_NS / `CLG_CLK_NS)

// Hundredths per second, minute, hour
`define CLG_H_PER_S 100
`define CLG_H_PER_M 6000
`define CLG_H_PER_HR 360000

`endif

// ### include/clg_pkg.sv
package clg_pkg;

   // Time base of the configured time value
   typedef enum logic [1:0]
   {
      CLG_TB_SEC = 2'b00,
      CLG_TB_MIN = 2'b01,
      CLG_TB_HR = 2'b11
   } clg_tbase_e;

   // Timer of the special function, Gray along idle-run-done
   typedef enum logic [1:0]
   {
      CLG_TM_IDLE = 2'b00,
      CLG_TM_RUN = 2'b01,
      CLG_TM_DONE = 2'b11
   } clg_tstate_e;

endpackage

// ### tb/clg_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module clg_top_props
#(
   parameter int ADDR_W = 8,
   parameter int PCYCLE_CYCLES = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [4:0] gate_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Cycles since the last output change; saturates so it never wraps
   int since_chg;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         since_chg <= PCYCLE_CYCLES;
      else if ($changed(gate_q))
         since_chg <= 1;
      else if (since_chg < 1000)
         since_chg <= since_chg + 1;
   end

   ////////////////////////////////////////////////////////////////////
   // Bus answer timing and address decode
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_access_a: assert property (!(psel && penable) |-> !pready)
      else $error("ready outside access phase");
   one_wait_a: assert property
      (psel && penable && !pready |=> pready)
      else $error("answer not in second access cycle");
   err_decode_a: assert property (psel && penable && pready |->
      pslverr == (paddr > 'h1c || paddr[1:0] != 2'h0))
      else $error("error flag does not match address");

   // Outputs of one tick come from the same inputs, so they agree
   nor_or_a: assert property (gate_q[2] != gate_q[1])
      else $error("nor equals or");
   xor_or_a: assert property (!gate_q[1] |-> !gate_q[3])
      else $error("xor high while or low");
   not_or_a: assert property (!gate_q[1] |-> gate_q[4])
      else $error("not low while or low");

   // Outputs move only on program ticks; edge output lasts one program cycle
   gate_tick_a: assert property
      ($changed(gate_q) |-> since_chg >= PCYCLE_CYCLES)
      else $error("outputs changed between program ticks");
   nand_fall_a: assert property
      ($fell(gate_q[0]) |-> since_chg == PCYCLE_CYCLES)
      else $error("edge output not one program cycle long");
endmodule

bind clg_top clg_top_props
#(
   .ADDR_W(ADDR_W),
   .PCYCLE_CYCLES(PCYCLE_CYCLES)
)
u_clg_top_props
(
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .gate_q(gate_q)
);

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "clg_consts.svh"

module tb_top;
   localparam int HC = 4;
   localparam int PC = 8;
   logic clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] gate_in;
   logic [6:0] sf_in;
   logic power_ok;
   logic [4:0] gate_q;
   logic sf_q;
   int err_total;
   int n_tests;
   int cyc;
   int n;
   logic [31:0] q;
   logic [31:0] h;
   logic [3:0] g;
   logic [4:0] e5;
   logic ok;
   // Register places with reset values; last two are unmapped
   logic [7:0] ra [10] = '{`CLG_OFF_CTRL, `CLG_OFF_INV, `CLG_OFF_CONN,
      `CLG_OFF_TIME, `CLG_OFF_LIMIT, `CLG_OFF_STATUS, `CLG_OFF_COUNT,
      `CLG_OFF_HOURS, 8'h20, 8'h02};
   logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h7ff, 32'h0, 32'ha, 32'h29,
      32'h0, 32'h0, 32'h0, 32'h0};
   // Gate rows: connected, inverted, pins, pulse, outputs
   logic [17:0] gt [6] = '{{4'hf, 4'h0, 4'he, 1'b1, 5'h1a},
      {4'h1, 4'h0, 4'h1, 1'b0, 5'h0a}, {4'h1, 4'h0, 4'h0, 1'b1, 5'h14},
      {4'hf, 4'h1, 4'h0, 1'b0, 5'h0a}, {4'hf, 4'hf, 4'h0, 1'b0, 5'h02},
      {4'hf, 4'hf, 4'h1, 1'b1, 5'h1a}};
   // Special function rows: pins, output, count
   logic [11:0] st [16] = '{12'h020, 12'h230, 12'h210, 12'h600, 12'h260,
      12'h200, 12'h281, 12'h201, 12'h282, 12'h202, 12'h293, 12'h313,
      12'h382, 12'h102, 12'h182, 12'h800};
   // Timer words in each base, with their length in clocks
   logic [31:0] tt [3] = '{32'h00003200, 32'h00010100, 32'h00030100};
   int tc [3] = '{50 * HC, 100 * HC, 6000 * HC};

   clg_top #(.HUND_CYCLES(HC), .PCYCLE_CYCLES(PC)) u_clg_top
   (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gate_in(gate_in),
      .sf_in(sf_in), .power_ok(power_ok), .gate_q(gate_q), .sf_q(sf_q)
   );

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic ee);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      chk("pslverr", 32'(ee), 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(nm, e, q);
   endtask

   // Pins need four sync flops plus up to two program ticks
   task automatic settle();
      repeat (3 * PC + 4)
         @(posedge clk);
   endtask

   task automatic wait_hi(input int s, input int lim, output int c);
      c = 0;
      while ((s != 0 ? sf_q : gate_q[0]) !== 1'b1 && c < lim)
      begin
         @(posedge clk);
         c++;
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever
         #2.5 clk = ~clk;
   end

   // Hang guard, well above the expected run length
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge clk);
         cyc++;
         if (cyc == 60000)
         begin
            err_total++;
            conclude();
         end
      end
   end

   initial
   begin
      err_total = 0;
      n_tests = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gate_in = 4'h0;
      sf_in = 7'h00;
      power_ok = 1'b1;
      repeat (10)
         @(posedge clk);
      rst_n <= 1'b1;
      settle();
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b0, ra[i], 32'h0, i > 7);
         chk("reg_reset", rv[i], q);
      end
      apb(1'b1, 8'h24, 32'hffffffff, 1'b1);
      $display("test registers done");
      for (int i = 0; i < 16; i++)
      begin
         gate_in <= 4'(i);
         settle();
         g = 4'(i);
         e5 = {~g[0], g[0] ^ g[1], ~|g, |g, 1'b0};
         chk("gate_q", 32'(e5), 32'(gate_q));
      end
      $display("test truth table done");
      for (int i = 0; i < 6; i++)
      begin
         wr(`CLG_OFF_CONN, {21'h0, 7'h7f, gt[i][17:14]});
         wr(`CLG_OFF_INV, {28'h0, gt[i][13:10]});
         gate_in <= gt[i][9:6];
         wait_hi(0, 24, n);
         chk("edge_pulse", 32'(gt[i][5]), 32'(n < 24));
         settle();
         chk("gate_q", 32'(gt[i][4:0]), 32'(gate_q));
      end
      wr(`CLG_OFF_INV, 32'h0);
      $display("test open and inverted inputs done");
      wr(`CLG_OFF_LIMIT, 32'h3);
      wr(`CLG_OFF_TIME, 32'h5);
      for (int i = 0; i < 16; i++)
      begin
         sf_in <= st[i][11:5];
         settle();
         chk("sf_q", 32'(st[i][4]), 32'(sf_q));
         rdc("count", `CLG_OFF_COUNT, 32'(st[i][3:0]));
      end
      $display("test special inputs done");
      for (int i = 0; i < 3; i++)
      begin
         sf_in <= 7'h50;
         wr(`CLG_OFF_TIME, tt[i]);
         settle();
         sf_in <= 7'h14;
         wait_hi(1, tc[i] + 40, n);
         ok = n >= tc[i] - 8 && n <= tc[i] + 32;
         chk("timer_span", 32'h1, 32'(ok));
      end
      $display("test time bases done");
      for (int r = 0; r < 2; r++)
      begin
         wr(`CLG_OFF_CTRL, 32'(r));
         sf_in <= 7'h50;
         settle();
         sf_in <= 7'h14;
         settle();
         sf_in <= 7'h10;
         settle();
         sf_in <= 7'h14;
         settle();
         apb(1'b0, `CLG_OFF_HOURS, 32'h0, 1'b0);
         h = q;
         power_ok <= 1'b0;
         repeat (60)
            @(posedge clk);
         power_ok <= 1'b1;
         settle();
         rdc("count_kept", `CLG_OFF_COUNT, r != 0 ? 32'h2 : 32'h0);
         rdc("hours_kept", `CLG_OFF_HOURS, h);
      end
      $display("test retention done");
      wr(`CLG_OFF_CTRL, 32'h4);
      wr(`CLG_OFF_LIMIT, 32'h7);
      rdc("limit_hidden", `CLG_OFF_LIMIT, 32'h0);
      wr(`CLG_OFF_CTRL, 32'h6);
      rdc("limit_prog", `CLG_OFF_LIMIT, 32'h3);
      wr(`CLG_OFF_LIMIT, 32'h7);
      wr(`CLG_OFF_CTRL, 32'h0);
      rdc("limit_open", `CLG_OFF_LIMIT, 32'h7);
      $display("test protection done");
      sf_in <= 7'h50;
      wr(`CLG_OFF_CONN, 32'h7ef);
      settle();
      sf_in <= 7'h11;
      settle();
      chk("sf_open", 32'h0, 32'(sf_q));
      $display("test open special input done");
      conclude();
   end
endmodule

`default_nettype wire

// ### verilog/clg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "clg_consts.svh"

module clg_top
#(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 16,
   parameter int HUND_CYCLES = `CLG_HUND_CYCLES,
   parameter int PCYCLE_CYCLES = `CLG_PCYCLE_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] gate_in,
   input wire logic [6:0] sf_in,
   input wire logic power_ok,
   output logic [4:0] gate_q,
   output logic sf_q
);

   localparam int SYN_W = 12;

   // Elaboration guard against settings the logic cannot serve
   if (HUND_CYCLES < 1 || PCYCLE_CYCLES < 2 || CNT_W < 2 || CNT_W > 32
       || ADDR_W < 5)
   begin : g_bad_param
      $error("clg_top: unsupported parameter value");
   end

   // Hundredths for a time value in its base
   function automatic logic [26:0] time_to_hund(input logic [17:0] t);
      logic [26:0] hi;
      logic [26:0] lo;
      hi = {19'h00000, t[7:0]};
      lo = {19'h00000, t[15:8]};
      case (clg_pkg::clg_tbase_e'(t[17:16]))
         clg_pkg::CLG_TB_MIN:
            time_to_hund = 27'(hi * `CLG_H_PER_M + lo * `CLG_H_PER_S);
         clg_pkg::CLG_TB_HR:
            time_to_hund = 27'(hi * `CLG_H_PER_HR + lo * `CLG_H_PER_M);
         default:
            time_to_hund = 27'(hi * `CLG_H_PER_S + lo);
      endcase
   endfunction

   logic [2:0] ctrl_reg;
   logic [10:0] inv_reg;
   logic [10:0] conn_reg;
   logic [17:0] time_reg;
   logic [15:0] limit_reg;
   logic [SYN_W-1:0] s1_reg;
   logic [SYN_W-1:0] s2_reg;
   logic [SYN_W-1:0] s3_reg;
   logic [SYN_W-1:0] stab_reg;
   logic [31:0] hdiv_reg;
   logic [31:0] pdiv_reg;
   logic hund_tick;
   logic prog_tick;
   logic [3:0] gprev_reg;
   logic [6:0] sfprev_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic latch_reg;
   clg_pkg::clg_tstate_e tstate_reg;
   logic [26:0] tleft_reg;
   logic [31:0] hours_reg;
   logic [3:0] g_in;
   logic [6:0] f_in;
   logic pwr_on;
   logic retain;
   logic param_open;
   logic wr_en;
   logic rd_en;
   logic trg_rise;
   logic [CNT_W-1:0] lim_ext;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         stab_reg <= '0;
      end
      else
      begin
         s1_reg <= {power_ok, sf_in, gate_in};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < SYN_W; i++)
         begin
            if (s2_reg[i] == s3_reg[i])
               stab_reg[i] <= s3_reg[i];
         end
      end
   end

   assign pwr_on = stab_reg[11];
   assign retain = ctrl_reg[`CLG_CTRL_RETAIN];

   // Inversion per input, then open special function inputs forced to zero
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         g_in[i] = stab_reg[i] ^ inv_reg[i];
      end
      for (int i = 0; i < 7; i++)
      begin
         f_in[i] = conn_reg[4+i] ? (stab_reg[4+i] ^ inv_reg[4+i]) : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Hundredth and program-cycle ticks; halted while power is off
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hdiv_reg <= '0;
         pdiv_reg <= '0;
      end
      else if (pwr_on)
      begin
         hdiv_reg <= hund_tick ? '0 : hdiv_reg + 32'h00000001;
         pdiv_reg <= prog_tick ? '0 : pdiv_reg + 32'h00000001;
      end
   end

   assign hund_tick = pwr_on && (hdiv_reg == 32'(HUND_CYCLES - 1));
   assign prog_tick = pwr_on && (pdiv_reg == 32'(PCYCLE_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////
   // Basic gates, evaluated once per program cycle
   // Prior-cycle copy of inputs feeds the edge evaluation
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gprev_reg <= 4'h0; // No false edge right after reset
         sfprev_reg <= 7'h00;
      end
      else if (prog_tick)
      begin
         for (int i = 0; i < 4; i++)
         begin
            gprev_reg[i] <= conn_reg[i] ? g_in[i] : 1'b1;
         end
         sfprev_reg <= f_in;
      end
   end

   // Open inputs: one for edge NAND, zero for OR, NOR, XOR
   always_ff @(posedge clk or negedge rst_n)
   begin
      logic [3:0] one_def;
      logic [3:0] zero_def;
      if (!rst_n)
         gate_q <= 5'h14; // NOR and NOT high for all-zero inputs
      else if (prog_tick)
      begin
         one_def = g_in | ~conn_reg[3:0];
         zero_def = g_in & conn_reg[3:0];
         gate_q[0] <= (~&one_def) && (&gprev_reg);
         gate_q[1] <= |zero_def;
         gate_q[2] <= ~|zero_def;
         gate_q[3] <= zero_def[0] ^ zero_def[1];
         gate_q[4] <= ~zero_def[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Special function: counter on trigger edges, direction-selected
   assign trg_rise = f_in[`CLG_SF_TRG] && !sfprev_reg[`CLG_SF_TRG];
   assign lim_ext = CNT_W'(limit_reg);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= '0;
      else if (!pwr_on && !retain)
         cnt_reg <= '0;
      else if (prog_tick)
      begin
         if (f_in[`CLG_SF_RST] || f_in[`CLG_SF_RAL])
            cnt_reg <= '0;
         else if (f_in[`CLG_SF_EN] && trg_rise)
         begin
            if (f_in[`CLG_SF_DIR])
               cnt_reg <= cnt_reg - 1'b1;
            else
               cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   // Set latch; reset wins over set
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         latch_reg <= 1'b0;
      else if (!pwr_on && !retain)
         latch_reg <= 1'b0;
      else if (prog_tick)
      begin
         if (f_in[`CLG_SF_RST] || f_in[`CLG_SF_RAL])
            latch_reg <= 1'b0;
         else if (f_in[`CLG_SF_EN] && f_in[`CLG_SF_SET])
            latch_reg <= 1'b1;
      end
   end

   // Timer started by trigger, counts hundredths; frozen while off if retain is set, else cleared
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tstate_reg <= clg_pkg::CLG_TM_IDLE;
         tleft_reg <= '0;
      end
      else if (!pwr_on && !retain)
      begin
         tstate_reg <= clg_pkg::CLG_TM_IDLE;
         tleft_reg <= '0;
      end
      else if (prog_tick && (f_in[`CLG_SF_RST] || f_in[`CLG_SF_RAL]))
      begin
         tstate_reg <= clg_pkg::CLG_TM_IDLE;
         tleft_reg <= '0;
      end
      else if (prog_tick && f_in[`CLG_SF_EN] && trg_rise)
      begin
         tstate_reg <= clg_pkg::CLG_TM_RUN;
         tleft_reg <= time_to_hund(time_reg);
      end
      else
      begin
         case (tstate_reg)
            clg_pkg::CLG_TM_RUN:
            begin
               // Remaining time resumes after power returns if retain is set
               if (hund_tick && f_in[`CLG_SF_EN])
               begin
                  if (tleft_reg <= 27'h0000001)
                  begin
                     tstate_reg <= clg_pkg::CLG_TM_DONE;
                     tleft_reg <= '0;
                  end
                  else
                     tleft_reg <= tleft_reg - 27'h0000001;
               end
            end
            clg_pkg::CLG_TM_DONE: tstate_reg <= clg_pkg::CLG_TM_DONE;
            default: tstate_reg <= clg_pkg::CLG_TM_IDLE;
         endcase
      end
   end

   // Output: reset forces low regardless of invert
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sf_q <= 1'b0;
      else if (!pwr_on && !retain)
         sf_q <= 1'b0;
      else if (prog_tick)
      begin
         if (f_in[`CLG_SF_RST])
            sf_q <= 1'b0;
         else
            sf_q <= (latch_reg || (cnt_reg >= lim_ext)
                     || tstate_reg == clg_pkg::CLG_TM_DONE)
                    ^ f_in[`CLG_SF_INV];
      end
   end

   // Operating time in hundredths; untouched by power loss
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hours_reg <= '0;
      else if (hund_tick && sf_q)
         hours_reg <= hours_reg + 32'h00000001;
   end

   ////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so read data comes from a flip-flop
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready && !pwrite;
   assign param_open = !ctrl_reg[`CLG_CTRL_PROT]
                       || ctrl_reg[`CLG_CTRL_PROG];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         case (paddr[4:0])
            5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c:
               pslverr <= psel && penable && !pready
                          && (paddr[ADDR_W-1:5] != '0 || paddr[1:0] != 2'h0);
            default: pslverr <= psel && penable && !pready;
         endcase
      end
   end

   // Register writes; parameter writes dropped while locked
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg <= `CLG_RST_CTRL;
         inv_reg <= `CLG_RST_INV;
         conn_reg <= `CLG_RST_CONN;
         time_reg <= `CLG_RST_TIME;
         limit_reg <= `CLG_RST_LIMIT;
      end
      else if (wr_en && !pslverr)
      begin
         case (paddr)
            `CLG_OFF_CTRL: ctrl_reg <= pwdata[2:0];
            `CLG_OFF_INV: inv_reg <= pwdata[10:0];
            `CLG_OFF_CONN: conn_reg <= pwdata[10:0];
            `CLG_OFF_TIME:
               if (param_open)
                  time_reg <= pwdata[17:0];
            `CLG_OFF_LIMIT:
               if (param_open)
                  limit_reg <= pwdata[15:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Read mux; locked parameters read as zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= '0;
      else if (rd_en)
      begin
         case (paddr)
            `CLG_OFF_CTRL: prdata <= {29'h0, ctrl_reg};
            `CLG_OFF_INV: prdata <= {21'h0, inv_reg};
            `CLG_OFF_CONN: prdata <= {21'h0, conn_reg};
            `CLG_OFF_TIME:
               prdata <= param_open ? {14'h0, time_reg} : '0;
            `CLG_OFF_LIMIT:
               prdata <= param_open ? {16'h0, limit_reg} : '0;
            `CLG_OFF_STATUS:
               prdata <= {24'h0, (tstate_reg == clg_pkg::CLG_TM_RUN),
                          sf_q, gate_q, pwr_on};
            `CLG_OFF_COUNT: prdata <= 32'(cnt_reg);
            `CLG_OFF_HOURS: prdata <= hours_reg;
            default: prdata <= '0;
         endcase
      end
   end

endmodule
`default_nettype wire
